// ---- tsm_defs.vh ----
// register map, field positions, reset values and timing counts of the status and error counter bank
`ifndef TSM_DEFS_VH
`define TSM_DEFS_VH

// register indices; apb byte address is four times the index
`define TSM_IDX_STATUS_TWO      7'h21
`define TSM_IDX_LCV_HIGH        7'h23
`define TSM_IDX_LCV_LOW         7'h24
`define TSM_IDX_PCV_HIGH        7'h25
`define TSM_IDX_PCV_LOW         7'h26
`define TSM_IDX_OOS_LOW         7'h27
`define TSM_IDX_MATCH_ONE       7'h29
`define TSM_IDX_MATCH_TWO       7'h2a
`define TSM_IDX_COUNTER_CTRL    7'h40
`define TSM_IDX_MASK_TWO        7'h6f
`define TSM_IDX_MASK_ONE        7'h7f

// status two and mask two field positions
`define TSM_BIT_RX_MULTIFRAME   7
`define TSM_BIT_TX_MULTIFRAME   6
`define TSM_BIT_ONE_SECOND      5
`define TSM_BIT_RX_LINK_FULL    4
`define TSM_BIT_TX_LINK_EMPTY   3
`define TSM_BIT_RX_LINK_MATCH   2
`define TSM_BIT_RX_LINK_ABORT   1

// counter control field positions
`define TSM_CTL_B8ZS_RX         0
`define TSM_CTL_FRAMING_ESF     1
`define TSM_CTL_EXCESS_ZERO     2
`define TSM_CTL_FS_ERROR        3
`define TSM_CTL_OOS_MODE        4
`define TSM_CTL_WIDTH           5

// reset values
`define TSM_MASK_RST            8'h00
`define TSM_MATCH_RST           8'h00
`define TSM_CTRL_RST            5'h00

// timing
`define TSM_CLK_PERIOD_NS       4
`define TSM_ONE_SEC_NS          1000000000
`define TSM_ONE_SEC_CYCLES      (`TSM_ONE_SEC_NS / `TSM_CLK_PERIOD_NS)

// run lengths
`define TSM_ZERO_RUN_PLAIN      5'h10
`define TSM_ZERO_RUN_B8ZS       5'h08
`define TSM_ABORT_RUN           5'h08

`endif

// ---- tsm_run_detect.v ----
// detector of a run of identical bits of programmable length
`timescale 1ns/1ps
`default_nettype none

module tsm_run_detect (
    input  wire       clk,
    input  wire       rst,
    input  wire       bitStrobe,
    input  wire       bitMatch,
    input  wire [4:0] runLen,
    output reg        runHit
);

    reg [4:0] run_q;

    // run restarts after a hit, so a run twice as long counts twice
    always @(posedge clk) begin
        if (rst) begin
            run_q  <= 5'h00;
            runHit <= 1'b0;
        end else begin
            runHit <= 1'b0;
            if (bitStrobe) begin
                if (!bitMatch) begin
                    run_q <= 5'h00;
                end else if (run_q + 5'h01 == runLen) begin
                    run_q  <= 5'h00;
                    runHit <= 1'b1;
                end else begin
                    run_q <= run_q + 5'h01;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- tsm_sat_counter.v ----
// saturating event counter with a held copy taken at each snapshot
`timescale 1ns/1ps
`default_nettype none

module tsm_sat_counter #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             incr,
    input  wire             snap,
    output reg  [WIDTH-1:0] held
);

    reg  [WIDTH-1:0] count_q;
    wire             atMax = &count_q;

    always @(posedge clk) begin
        if (rst) begin
            count_q <= {WIDTH{1'b0}};
            held    <= {WIDTH{1'b0}};
        end else if (snap) begin
            // event on the boundary edge belongs to the new second
            held    <= count_q;
            count_q <= {{(WIDTH-1){1'b0}}, incr};
        end else if (incr && !atMax) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule
`default_nettype wire

// ---- tsm_status_counters.v ----
// status two flags, interrupt masks and one-second error counters behind an apb slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defs.vh"

module tsm_status_counters #(
    parameter [31:0] ONE_SEC_CYCLES = `TSM_ONE_SEC_CYCLES
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         intN,
    input  wire [7:0]  statusOne,
    input  wire        rxMultiframeEvt,
    input  wire        txMultiframeEvt,
    input  wire        rxLinkFullEvt,
    input  wire [7:0]  rxLinkByte,
    input  wire        txLinkEmptyEvt,
    input  wire        rxLinkBitStrobe,
    input  wire        rxLinkBit,
    input  wire        bipolarViolEvt,
    input  wire        b8zsWordEvt,
    input  wire        rxBitStrobe,
    input  wire        rxBitZero,
    input  wire        crcErrEvt,
    input  wire        ftErrEvt,
    input  wire        fsErrEvt,
    input  wire        fpsErrEvt,
    input  wire        mfOutOfSyncEvt
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    function addrHits;
        input [11:0] addr;
        input [6:0]  idx;
        begin
            addrHits = (addr == {3'b000, idx, 2'b00});
        end
    endfunction

    reg  [7:0]             maskOne_q;
    reg  [7:0]             maskTwo_q;
    reg  [7:0]             matchOne_q;
    reg  [7:0]             matchTwo_q;
    reg  [`TSM_CTL_WIDTH-1:0] ctrl_q;
    reg  [7:1]             flags_q;
    reg  [31:0]            secCnt_q;
    reg                    secTick_q;

    wire                   setupPhase = psel && !penable;
    wire                   apbDone    = psel && penable && pready;
    wire                   wrDone     = apbDone && pwrite;
    wire                   sr2ReadClr = apbDone && !pwrite && addrHits(paddr, `TSM_IDX_STATUS_TWO);

    wire                   b8zsOn     = ctrl_q[`TSM_CTL_B8ZS_RX];
    wire                   esfMode    = ctrl_q[`TSM_CTL_FRAMING_ESF];
    wire                   zeroCntOn  = ctrl_q[`TSM_CTL_EXCESS_ZERO];
    wire                   fsCntOn    = ctrl_q[`TSM_CTL_FS_ERROR];
    wire                   oosMode    = ctrl_q[`TSM_CTL_OOS_MODE];
    wire                   syncLoss   = statusOne[0];

    ////////////////////////////////////////////////////////////////////////////////
    // one-second timer

    always @(posedge clk) begin
        if (rst) begin
            secCnt_q  <= 32'h0000_0000;
            secTick_q <= 1'b0;
        end else if (secCnt_q == ONE_SEC_CYCLES - 32'h0000_0001) begin
            secCnt_q  <= 32'h0000_0000;
            secTick_q <= 1'b1;
        end else begin
            secCnt_q  <= secCnt_q + 32'h0000_0001;
            secTick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link events and status two flags

    wire       abortHit;
    wire       zeroHit;
    wire [4:0] zeroRunLen = b8zsOn ? `TSM_ZERO_RUN_B8ZS : `TSM_ZERO_RUN_PLAIN;
    wire       linkMatch  = rxLinkFullEvt && (rxLinkByte == matchOne_q || rxLinkByte == matchTwo_q);

    tsm_run_detect uAbortRun (
        .clk       (clk),
        .rst       (rst),
        .bitStrobe (rxLinkBitStrobe),
        .bitMatch  (rxLinkBit),
        .runLen    (`TSM_ABORT_RUN),
        .runHit    (abortHit)
    );

    wire [7:1] flagSet;
    assign flagSet[`TSM_BIT_RX_MULTIFRAME] = rxMultiframeEvt;
    assign flagSet[`TSM_BIT_TX_MULTIFRAME] = txMultiframeEvt;
    assign flagSet[`TSM_BIT_ONE_SECOND]    = secTick_q;
    assign flagSet[`TSM_BIT_RX_LINK_FULL]  = rxLinkFullEvt;
    assign flagSet[`TSM_BIT_TX_LINK_EMPTY] = txLinkEmptyEvt;
    assign flagSet[`TSM_BIT_RX_LINK_MATCH] = linkMatch;
    assign flagSet[`TSM_BIT_RX_LINK_ABORT] = abortHit;

    // a read clears only the bits it returned, so a flag raised after capture survives
    genvar gi;
    generate
        for (gi = 1; gi < 8; gi = gi + 1) begin : gFlag
            always @(posedge clk) begin
                if (rst) begin
                    flags_q[gi] <= 1'b0;
                end else begin
                    flags_q[gi] <= (flags_q[gi] && !(sr2ReadClr && prdata[gi])) || flagSet[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // error counters

    tsm_run_detect uZeroRun (
        .clk       (clk),
        .rst       (rst),
        .bitStrobe (rxBitStrobe),
        .bitMatch  (rxBitZero),
        .runLen    (zeroRunLen),
        .runHit    (zeroHit)
    );

    // coincident violation and zero run count once; they almost never share a bit time
    wire lcvIncr = (bipolarViolEvt && !(b8zsOn && b8zsWordEvt))
                   || (zeroCntOn && zeroHit);
    wire pcvErr  = esfMode ? crcErrEvt
                           : (ftErrEvt || (fsCntOn && fsErrEvt));
    wire pcvIncr = pcvErr && !syncLoss;
    wire oosIncr = oosMode ? mfOutOfSyncEvt
                           : ((esfMode ? fpsErrEvt : ftErrEvt) && !syncLoss);

    wire [15:0] lcvHeld;
    wire [11:0] pcvHeld;
    wire [11:0] oosHeld;

    tsm_sat_counter #(.WIDTH(16)) uLineCount (
        .clk  (clk),
        .rst  (rst),
        .incr (lcvIncr),
        .snap (secTick_q),
        .held (lcvHeld)
    );

    tsm_sat_counter #(.WIDTH(12)) uPathCount (
        .clk  (clk),
        .rst  (rst),
        .incr (pcvIncr),
        .snap (secTick_q),
        .held (pcvHeld)
    );

    tsm_sat_counter #(.WIDTH(12)) uOosCount (
        .clk  (clk),
        .rst  (rst),
        .incr (oosIncr),
        .snap (secTick_q),
        .held (oosHeld)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register writes

    always @(posedge clk) begin
        if (rst) begin
            maskOne_q  <= `TSM_MASK_RST;
            maskTwo_q  <= `TSM_MASK_RST;
            matchOne_q <= `TSM_MATCH_RST;
            matchTwo_q <= `TSM_MATCH_RST;
            ctrl_q     <= `TSM_CTRL_RST;
        end else if (wrDone) begin
            if (addrHits(paddr, `TSM_IDX_MASK_ONE)) begin
                maskOne_q <= pwdata[7:0];
            end
            if (addrHits(paddr, `TSM_IDX_MASK_TWO)) begin
                maskTwo_q <= {pwdata[7:1], 1'b0};
            end
            if (addrHits(paddr, `TSM_IDX_MATCH_ONE)) begin
                matchOne_q <= pwdata[7:0];
            end
            if (addrHits(paddr, `TSM_IDX_MATCH_TWO)) begin
                matchTwo_q <= pwdata[7:0];
            end
            if (addrHits(paddr, `TSM_IDX_COUNTER_CTRL)) begin
                ctrl_q <= pwdata[`TSM_CTL_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux

    reg [7:0] rdData;
    reg       rdMapped;

    always @* begin
        rdData   = 8'h00;
        rdMapped = 1'b1;
        if (addrHits(paddr, `TSM_IDX_STATUS_TWO)) begin
            rdData = {flags_q, 1'b0};
        end else if (addrHits(paddr, `TSM_IDX_LCV_HIGH)) begin
            rdData = lcvHeld[15:8];
        end else if (addrHits(paddr, `TSM_IDX_LCV_LOW)) begin
            rdData = lcvHeld[7:0];
        end else if (addrHits(paddr, `TSM_IDX_PCV_HIGH)) begin
            rdData = {oosHeld[11:8], pcvHeld[11:8]};
        end else if (addrHits(paddr, `TSM_IDX_PCV_LOW)) begin
            rdData = pcvHeld[7:0];
        end else if (addrHits(paddr, `TSM_IDX_OOS_LOW)) begin
            rdData = oosHeld[7:0];
        end else if (addrHits(paddr, `TSM_IDX_MATCH_ONE)) begin
            rdData = matchOne_q;
        end else if (addrHits(paddr, `TSM_IDX_MATCH_TWO)) begin
            rdData = matchTwo_q;
        end else if (addrHits(paddr, `TSM_IDX_COUNTER_CTRL)) begin
            rdData = {3'b000, ctrl_q};
        end else if (addrHits(paddr, `TSM_IDX_MASK_TWO)) begin
            rdData = maskTwo_q;
        end else if (addrHits(paddr, `TSM_IDX_MASK_ONE)) begin
            rdData = maskOne_q;
        end else begin
            rdMapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb answer: data captured in setup, ready for exactly the access cycle

    always @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            if (setupPhase) begin
                prdata  <= {24'h00_0000, rdData};
                pslverr <= !rdMapped;
            end else if (apbDone) begin
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt output

    wire irqAny = |(statusOne & maskOne_q)
                  || |({flags_q, 1'b0} & maskTwo_q);

    always @(posedge clk) begin
        if (rst) begin
            intN <= 1'b1;
        end else begin
            intN <= !irqAny;
        end
    end

endmodule
`default_nettype wire

// ---- tsm_status_counters_chk.sv ----
// assertions on the port behaviour of the status and error counter bank
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defs.vh"
module tsm_status_counters_chk #(
    parameter [31:0] ONE_SEC_CYCLES = 200
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        intN,
    input wire logic [7:0]  statusOne,
    input wire logic        rxMultiframeEvt,
    input wire logic        txMultiframeEvt,
    input wire logic        rxLinkFullEvt,
    input wire logic        txLinkEmptyEvt
);
    localparam [11:0] ADR_M1 = {3'h0, `TSM_IDX_MASK_ONE, 2'h0};
    localparam [11:0] ADR_M2 = {3'h0, `TSM_IDX_MASK_TWO, 2'h0};
    logic [7:0]  maskOne_q;
    logic [7:0]  maskTwo_q;
    logic [31:0] hiCnt_q;
    wire         done = psel && penable && pready;
    ////////////////////////////////////////////////////////////
    // mask copies follow completed writes; hiCnt times a masked-in idle line
    always @(posedge clk) begin
        if (rst) begin
            maskOne_q <= 8'h00;
            maskTwo_q <= 8'h00;
            hiCnt_q   <= 32'h0;
        end else begin
            if (done && pwrite && paddr == ADR_M1) maskOne_q <= pwdata[7:0];
            if (done && pwrite && paddr == ADR_M2) maskTwo_q <= {pwdata[7:1], 1'b0};
            hiCnt_q <= (maskTwo_q[5] && intN) ? hiCnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_stat1_irq: assert property ((|(statusOne & maskOne_q)) |=> !intN)
        else $error("no interrupt for enabled status one");
    chk_rxmf_irq: assert property (rxMultiframeEvt ##1 maskTwo_q[7] |-> ##1 !intN)
        else $error("no interrupt for rx multiframe");
    chk_txmf_irq: assert property (txMultiframeEvt ##1 maskTwo_q[6] |-> ##1 !intN)
        else $error("no interrupt for tx multiframe");
    chk_full_irq: assert property (rxLinkFullEvt ##1 maskTwo_q[4] |-> ##1 !intN)
        else $error("no interrupt for link full");
    chk_empty_irq: assert property (txLinkEmptyEvt ##1 maskTwo_q[3] |-> ##1 !intN)
        else $error("no interrupt for link empty");
    chk_sec_bound: assert property (hiCnt_q <= ONE_SEC_CYCLES + 32'd4)
        else $error("one second interrupt overdue");
    chk_mask1_read: assert property (done && !pwrite && paddr == ADR_M1 |-> prdata[7:0] == maskOne_q)
        else $error("mask one read back wrong");
    chk_mask2_read: assert property (done && !pwrite && paddr == ADR_M2 |-> prdata[7:0] == maskTwo_q)
        else $error("mask two read back wrong");
    cover property (rxLinkFullEvt ##2 !intN);
    cover property (!intN && maskTwo_q[5]);
    cover property (done && !pwrite && paddr == ADR_M1);
endmodule
bind tsm_status_counters tsm_status_counters_chk #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) u_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .intN(intN), .statusOne(statusOne),
    .rxMultiframeEvt(rxMultiframeEvt), .txMultiframeEvt(txMultiframeEvt),
    .rxLinkFullEvt(rxLinkFullEvt), .txLinkEmptyEvt(txLinkEmptyEvt));
`default_nettype wire

// ---- tsm_apb_host.sv ----
// apb host model that reaches the bank registers
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defs.vh"
module tsm_apb_host (
    input  wire logic        clk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic timedOut = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    ////////////////////////////////////////////////////////////
    // pready sampled at the rising edge that completes the access, request released there
    task automatic xfer(input logic wr, input logic [6:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {3'h0, idx, 2'h0};
        pwdata  <= {24'h0, wd[7:1], wd[0] && idx != `TSM_IDX_MASK_TWO};
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        timedOut = (i == 16);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tsm_status_counters_test.sv ----
// self-checking bench of the status and error counter bank
`timescale 1ns/1ps
`default_nettype none
`include "tsm_defs.vh"
module tsm_status_counters_test;
    localparam [31:0] SEC = 32'd4400;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, intN, linkStb, linkBit, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  statusOne, rxLinkByte, ev, rd, hv, m, mb;
    logic [3:0]  fl, oh;
    int          nErrors, samplesChecked, i, k, n;
    logic [7:0]  ctlTab [11] = '{8'h00, 8'h11, 8'h01, 8'h04, 8'h05, 8'h0a, 8'h02, 8'h00, 8'h08, 8'h00, 8'h02};
    logic [7:0]  patTab [11] = '{8'h01, 8'h83, 8'h01, 8'h04, 8'h04, 8'h30, 8'h48, 8'h20, 8'h30, 8'h10, 8'h08};
    logic [7:0]  expTab [6]  = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h14, 8'h02};
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    tsm_status_counters #(.ONE_SEC_CYCLES(SEC)) u_tsm_status_counters (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .intN(intN),
        .statusOne(statusOne), .rxMultiframeEvt(fl[0]), .txMultiframeEvt(fl[1]), .rxLinkFullEvt(fl[2]),
        .rxLinkByte(rxLinkByte), .txLinkEmptyEvt(fl[3]), .rxLinkBitStrobe(linkStb), .rxLinkBit(linkBit),
        .bipolarViolEvt(ev[0]), .b8zsWordEvt(ev[1]), .rxBitStrobe(ev[2]), .rxBitZero(ev[2]),
        .crcErrEvt(ev[3]), .ftErrEvt(ev[4]), .fsErrEvt(ev[5]), .fpsErrEvt(ev[6]), .mfOutOfSyncEvt(ev[7]));
    tsm_apb_host host (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic endSim;
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rw(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
        host.xfer(wr, idx, wd, rd, err);
        if (host.timedOut) begin
            nErrors++;
            endSim();
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask
    task automatic burst(input logic [7:0] pat, input int c);
        repeat (c) begin
            @(posedge clk);
            ev <= pat;
        end
        @(posedge clk);
        ev <= 8'h00;
    endtask
    // polling clears the flag, so a stale one only costs one extra call
    task automatic waitTick;
        int j;
        for (j = 0; j < 4000; j++) begin
            rw(1'b0, `TSM_IDX_STATUS_TWO, 8'h00);
            if (rd[`TSM_BIT_ONE_SECOND] === 1'b1) return;
        end
        nErrors++;
        endSim();
    endtask
    function automatic logic [15:0] expLine(logic [7:0] c, logic [7:0] p, int cnt);
        if (p[2]) return c[2] ? cnt / (c[0] ? 8 : 16) : 0;
        return (p[0] && !(c[0] && p[1])) ? cnt : 0;
    endfunction
    function automatic logic [15:0] expPath(logic [7:0] c, logic [7:0] p, int cnt, logic loss);
        int v;
        v = loss ? 0 : c[1] ? (p[3] ? cnt : 0) : ((p[4] || (c[3] && p[5])) ? cnt : 0);
        return v > 4095 ? 4095 : v;
    endfunction
    // multiframe mode counts regardless of sync; f-bit mode halts in sync loss
    function automatic logic [15:0] expOos(logic [7:0] c, logic [7:0] p, int cnt, logic loss);
        if (c[4]) return p[7] ? cnt : 0;
        return ((c[1] ? p[6] : p[4]) && !loss) ? cnt : 0;
    endfunction
    ////////////////////////////////////////////////////////////
    initial begin
        {statusOne, rxLinkByte, ev, fl, linkStb, linkBit} = '0;
        rst = 1'b1;
        nErrors = 0;
        samplesChecked = 0;
        void'($urandom(66450));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rw(1'b0, 7'h22, 8'h00);
        chk("unmapped", {7'h0, err, rd}, 16'h0100);
        rw(1'b1, `TSM_IDX_LCV_HIGH, 8'($urandom));
        rw(1'b0, `TSM_IDX_LCV_HIGH, 8'h00);
        chk("read-only line high", rd, 8'h00);
        for (k = 0; k < 4; k++) begin
            m = 8'($urandom);
            rw(1'b1, `TSM_IDX_MASK_ONE, m);
            statusOne <= 8'($urandom);
            cyc(3);
            chk("intN status one", intN, !(|(m & statusOne)));
            rw(1'b0, `TSM_IDX_MASK_ONE, 8'h00);
            chk("mask one", rd, m);
        end
        statusOne <= 8'h00;
        rw(1'b1, `TSM_IDX_MASK_ONE, 8'h00);
        $display("registers done");
        mb = 8'($urandom) | 8'h01;
        rw(1'b1, `TSM_IDX_MATCH_ONE, mb);
        rw(1'b1, `TSM_IDX_MATCH_TWO, mb ^ 8'h80);
        for (k = 0; k < 6; k++) begin
            m = 8'($urandom) & 8'hde;
            rw(1'b1, `TSM_IDX_MASK_TWO, m);
            rxLinkByte <= (k == 4) ? mb ^ 8'h80 : mb ^ 8'h01;
            fl         <= (k < 4) ? 4'h1 << k : (k == 4) ? 4'h4 : 4'h0;
            linkStb    <= (k == 5);
            linkBit    <= 1'b1;
            repeat ((k == 5) ? 8 : 1) @(posedge clk);
            fl      <= 4'h0;
            linkStb <= 1'b0;
            cyc(3);
            chk("intN flag", intN, !(|(m & expTab[k])));
            rw(1'b0, `TSM_IDX_STATUS_TWO, 8'h00);
            chk("status two", rd & 8'hdf, expTab[k]);
            rw(1'b0, `TSM_IDX_STATUS_TWO, 8'h00);
            cyc(2);
            chk("intN cleared", {rd & 8'hdf, intN}, 16'h0001);
        end
        rw(1'b1, `TSM_IDX_MASK_TWO, 8'h20);
        for (k = 0; k < SEC + 8 && intN === 1'b1; k++) @(posedge clk);
        chk("intN second", intN, 1'b0);
        rw(1'b1, `TSM_IDX_MASK_TWO, 8'h00);
        $display("flags done");
        waitTick();
        waitTick();
        for (i = 0; i < 11; i++) begin
            n = (i == 10) ? 4200 : patTab[i][2] ? 16 * (1 + $urandom % 3) : 1 + $urandom % 60;
            statusOne <= {7'h0, i[0]};
            rw(1'b1, `TSM_IDX_COUNTER_CTRL, ctlTab[i]);
            burst(patTab[i], n);
            waitTick();
            rw(1'b0, `TSM_IDX_LCV_HIGH, 8'h00);
            hv = rd;
            rw(1'b0, `TSM_IDX_LCV_LOW, 8'h00);
            chk("line count", {hv, rd}, expLine(ctlTab[i], patTab[i], n));
            rw(1'b0, `TSM_IDX_PCV_HIGH, 8'h00);
            hv = rd & 8'h0f;
            oh = rd[7:4];
            rw(1'b0, `TSM_IDX_PCV_LOW, 8'h00);
            chk("path count", {hv, rd}, expPath(ctlTab[i], patTab[i], n, i[0]));
            rw(1'b0, `TSM_IDX_OOS_LOW, 8'h00);
            chk("oos count", {4'h0, oh, rd}, expOos(ctlTab[i], patTab[i], n, i[0]));
        end
        $display("counters done");
        endSim();
    end
endmodule
`default_nettype wire
